// *** logic/balance_pin_pulse_sequencer.sv ***
// Balancing pin pulse sequencer: serial command port, per-pin control
// nibbles, pulse train generator and an APB register slave.
// Assumes sck and csb_n come from an off-chip host on their own clock and
// that clk runs at 200 MHz.
//
// Overview of operation
// - Fifteen control nibbles each select steady high, low or 1 to 7 pulses.
// - Pulses repeat every 155 us and each one lasts 77.6 us.
// - Pulsing starts after the start command's check word, if it is correct.
// - While polled after the start, the data output is held low until done.
// - Start and both pin-control writes are discarded while pulsing runs.
// - The polling command also reports pulse completion on the data output.
// - A write with a good command check but bad data check clears all nibbles.
// - A set discharge bit forces its pin low, whatever its nibble says.
// - The clear command zeroes every nibble and stops pulsing at once.
// - Mute disables all pins and resume enables them, with no data bytes.
// - Mute and resume leave every register value but the status mute bit as it was.
// - The mute state is reported in a read-only status bit.
// - The port works as a four-wire serial port when its mode pin is low.
// - The port runs with clock polarity 1 and phase 1, sampling on rising.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "balance_pin_pulse_sequencer_defs.svh"

module balance_pin_pulse_sequencer #(
  parameter int unsigned PINS       = 15,
  parameter int unsigned PERIOD_CYC = `PULSE_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int unsigned WIDTH_CYC  = `PULSE_WIDTH_NS / `CLK_PERIOD_NS
) (
  // System clock, reset and clock enable.
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Serial command port, link clock domain.
  input  wire logic              sck,
  input  wire logic              csb_n,
  input  wire logic              sdi,
  output logic                   sdo_out,
  output logic                   sdo_oe,
  input  wire logic              port_a_mode_select_pin,
  // Balancing output pins.
  output logic [PINS-1:0]        balance_pin
);

  // Check code over one 16-bit word, chained from a running value.
  function automatic logic [15:0] check_code(input logic [15:0] seed,
                                             input logic [15:0] word);
    logic [15:0] c;
    logic        fb;
    c = seed;
    for (int i = 15; i >= 0; i--) begin
      fb = word[i] ^ c[15];
      c  = {c[14:0], 1'b0} ^ (fb ? `CHECK_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Link domain: shift in on rising sck, a word every sixteen bits.
  logic [3:0]  bit_cnt;
  logic [15:0] shift_in;
  logic [15:0] word_hold;
  logic        word_tgl;
  logic [1:0]  hold_low_sync;
  logic        hold_low_q; // Written on clk, crossed into sck below.
  // Bit count restarts whenever the frame is closed by csb_n.
  always_ff @(posedge sck or posedge csb_n or posedge rst) begin
    if (rst || csb_n) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // The toggle is never reset by csb_n, so a frame end makes no false event.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      shift_in  <= 16'h0000;
      word_hold <= 16'h0000;
      word_tgl  <= 1'b0;
    end else if (!csb_n) begin
      shift_in <= {shift_in[14:0], sdi};
      if (bit_cnt == 4'hF) begin
        word_hold <= {shift_in[14:0], sdi};
        word_tgl  <= ~word_tgl;
      end
    end
  end

  // The hold-low level crosses on sck edges; polling supplies them.
  // Cleared between frames, so a stale level never leaks into the next one.
  always_ff @(posedge sck or posedge rst or posedge csb_n) begin
    if (rst || csb_n) begin
      hold_low_sync <= 2'b00;
    end else begin
      hold_low_sync <= {hold_low_sync[0], hold_low_q};
    end
  end

  // Open-drain data output changes on the falling edge, as mode 3 expects,
  // and lets go of the line the moment the frame is closed.
  always_ff @(negedge sck or posedge rst or posedge csb_n) begin
    if (rst || csb_n) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= hold_low_sync[1];
    end
  end

  assign sdo_out = 1'b0;

  // System domain: synchronisers for the word toggle and the pins.
  logic [2:0] tgl_sync;
  logic [1:0] csb_sync;
  logic [1:0] mode_sync;
  logic       word_evt;
  logic       frame_open;
  logic       four_wire;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_sync  <= 3'b000;
      csb_sync  <= 2'b11;
      mode_sync <= 2'b11;
    end else if (ce) begin
      tgl_sync  <= {tgl_sync[1:0], word_tgl};
      csb_sync  <= {csb_sync[0], csb_n};
      mode_sync <= {mode_sync[0], port_a_mode_select_pin};
    end
  end

  assign frame_open = ~csb_sync[1];
  assign four_wire  = ~mode_sync[1];
  // The held word is quiet for sixteen sck periods, far beyond the crossing.
  assign word_evt   = (tgl_sync[2] ^ tgl_sync[1]) & four_wire & frame_open;

  // Command decoder state.
  balance_pin_pulse_sequencer_pkg::frame_state_t state;
  logic [15:0]       cmd;
  logic [15:0]       data_chk;
  logic [1:0]        words_left;
  logic              group_b;
  logic [47:0]       data_acc;
  logic              start_req, clear_req, commit_req, wipe_req;
  logic              mute;
  logic              data_err;
  logic              busy;
  // Frame decoder: command, its check word, then any data and data check.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= balance_pin_pulse_sequencer_pkg::st_cmd;
      cmd        <= 16'h0000;
      data_chk   <= 16'h0000;
      words_left <= 2'h0;
      group_b    <= 1'b0;
      data_acc   <= 48'h0000_0000_0000;
      start_req  <= 1'b0;
      clear_req  <= 1'b0;
      commit_req <= 1'b0;
      wipe_req   <= 1'b0;
      mute       <= 1'b0;
      data_err   <= 1'b0;
    end else if (ce) begin
      start_req  <= 1'b0;
      clear_req  <= 1'b0;
      commit_req <= 1'b0;
      wipe_req   <= 1'b0;
      if (!frame_open) begin
        state <= balance_pin_pulse_sequencer_pkg::st_cmd;
      end else if (word_evt) begin
        case (state)
          balance_pin_pulse_sequencer_pkg::st_cmd: begin
            cmd   <= word_hold;
            state <= balance_pin_pulse_sequencer_pkg::st_chk;
          end
          balance_pin_pulse_sequencer_pkg::st_chk: begin
            state <= balance_pin_pulse_sequencer_pkg::st_skip;
            if (word_hold == check_code(`CHECK_SEED, cmd)) begin
              case (cmd)
                `CMD_START_PULSING: begin
                  start_req <= ~busy;
                  state     <= balance_pin_pulse_sequencer_pkg::st_poll;
                end
                `CMD_POLL_CONV: begin
                  state <= balance_pin_pulse_sequencer_pkg::st_poll;
                end
                `CMD_CLEAR_PINS: clear_req <= 1'b1;
                `CMD_MUTE: mute <= 1'b1;
                `CMD_RESUME: mute <= 1'b0;
                `CMD_WRITE_PINS, `CMD_WRITE_GROUP_B: begin
                  if (!busy) begin
                    group_b    <= (cmd == `CMD_WRITE_GROUP_B);
                    words_left <= (cmd == `CMD_WRITE_GROUP_B) ?
                                  `WORDS_GROUP_B : `WORDS_GROUP_A;
                    data_chk   <= `CHECK_SEED;
                    state      <= balance_pin_pulse_sequencer_pkg::st_data;
                  end
                end
                default: state <= balance_pin_pulse_sequencer_pkg::st_skip;
              endcase
            end
          end
          balance_pin_pulse_sequencer_pkg::st_data: begin
            data_acc   <= {data_acc[31:0], word_hold};
            data_chk   <= check_code(data_chk, word_hold);
            words_left <= words_left - 2'h1;
            if (words_left == 2'h1) begin
              state <= balance_pin_pulse_sequencer_pkg::st_dchk;
            end
          end
          balance_pin_pulse_sequencer_pkg::st_dchk: begin
            if (word_hold == data_chk) begin
              commit_req <= 1'b1;
              data_err   <= 1'b0;
            end else begin
              wipe_req <= 1'b1;
              data_err <= 1'b1;
            end
            state <= balance_pin_pulse_sequencer_pkg::st_skip;
          end
          default: state <= state;
        endcase
      end
    end
  end

  // Control nibbles; pins 0 to 11 from group A, 12 to 14 from group B.
  logic [4*PINS-1:0] nibbles;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nibbles <= '0;
    end else if (ce) begin
      if (clear_req || wipe_req) begin
        nibbles <= '0;
      end else if (commit_req && !busy) begin
        if (group_b) begin
          nibbles[4*PINS-1:48] <= data_acc[4*PINS-49:0];
        end else begin
          nibbles[47:0] <= data_acc;
        end
      end
    end
  end

  // Longest programmed train, so completion waits for every pin.
  logic [3:0] longest;
  always_comb begin
    longest = 4'h0;
    for (int i = 0; i < PINS; i++) begin
      if (nibbles[4*i +: 4] <= `NIB_PULSE_MAX &&
          nibbles[4*i +: 4] > longest) begin
        longest = nibbles[4*i +: 4];
      end
    end
  end

  // Shared timebase for all pulsing pins.
  logic [31:0] phase;
  logic [3:0]  pulse_idx;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy      <= 1'b0;
      phase     <= 32'h0000_0000;
      pulse_idx <= 4'h0;
    end else if (ce) begin
      if (clear_req) begin
        busy <= 1'b0;
      end else if (start_req && !busy) begin
        busy      <= (longest != 4'h0);
        phase     <= 32'h0000_0000;
        pulse_idx <= 4'h0;
      end else if (busy) begin
        if (phase == PERIOD_CYC - 1) begin
          phase     <= 32'h0000_0000;
          pulse_idx <= pulse_idx + 4'h1;
          if (pulse_idx + 4'h1 == longest) begin
            busy <= 1'b0;
          end
        end else begin
          phase <= phase + 32'h0000_0001;
        end
      end
    end
  end

  // Polled data output is held low only in a poll while pulsing runs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_low_q <= 1'b0;
    end else if (ce) begin
      hold_low_q <= busy && frame_open &&
                    state == balance_pin_pulse_sequencer_pkg::st_poll;
    end
  end

  // Pin drive: mute and discharge bits override the nibble.
  logic [PINS-1:0] discharge_cell_bit;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      balance_pin <= '0;
    end else if (ce) begin
      for (int i = 0; i < PINS; i++) begin
        if (mute || discharge_cell_bit[i]) begin
          balance_pin[i] <= 1'b0;
        end else if (nibbles[4*i +: 4] == `NIB_HIGH) begin
          balance_pin[i] <= 1'b1;
        end else begin
          balance_pin[i] <= busy && nibbles[4*i +: 4] != 4'h0 &&
                            nibbles[4*i +: 4] <= `NIB_PULSE_MAX &&
                            pulse_idx < nibbles[4*i +: 4] &&
                            phase < WIDTH_CYC;
        end
      end
    end
  end

  // APB slave: zero wait states, frozen with the rest while ce is low.
  logic apb_hit;
  logic apb_map;
  assign pready  = ce;
  assign apb_hit = psel && penable && ce;
  assign apb_map = paddr == `REG_DISCHARGE_OFS || paddr == `REG_STATUS_OFS ||
                   paddr == `REG_NIBBLE_LO_OFS || paddr == `REG_NIBBLE_HI_OFS;
  assign pslverr = psel && penable && !apb_map;

  // Discharge bits are the only writable register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      discharge_cell_bit <= `DISCHARGE_RST;
    end else if (apb_hit && pwrite && paddr == `REG_DISCHARGE_OFS) begin
      discharge_cell_bit <= pwdata[PINS-1:0];
    end
  end

  // Read data is registered during the setup phase, ready for the access.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      case (paddr)
        `REG_DISCHARGE_OFS: prdata <= {17'h0_0000, discharge_cell_bit};
        `REG_STATUS_OFS: begin
          prdata                 <= 32'h0000_0000;
          prdata[`STAT_BUSY_BIT] <= busy;
          prdata[`STAT_MUTE_BIT] <= mute;
          prdata[`STAT_FOUR_BIT] <= four_wire;
          prdata[`STAT_DERR_BIT] <= data_err;
        end
        `REG_NIBBLE_LO_OFS: prdata <= nibbles[31:0];
        `REG_NIBBLE_HI_OFS: prdata <= {4'h0, nibbles[4*PINS-1:32]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // balance_pin_pulse_sequencer
`default_nettype wire

// *** logic/balance_pin_pulse_sequencer_defs.svh ***
// Constants of the balancing pin pulse sequencer: register offsets, reset
// values, command codes, check code settings, nibble codes and timing.
// Assumes byte addressing on a 32-bit APB bus, one register per word.
`ifndef BALANCE_PIN_PULSE_SEQUENCER_DEFS_SVH
`define BALANCE_PIN_PULSE_SEQUENCER_DEFS_SVH

// Register byte offsets.
`define REG_DISCHARGE_OFS 8'h00
`define REG_STATUS_OFS    8'h04
`define REG_NIBBLE_LO_OFS 8'h08
`define REG_NIBBLE_HI_OFS 8'h0C

// Register reset values.
`define DISCHARGE_RST 15'h0000

// Status register bit positions.
`define STAT_BUSY_BIT  0
`define STAT_MUTE_BIT  1
`define STAT_FOUR_BIT  2
`define STAT_DERR_BIT  3

// Command codes on the serial port.
`define CMD_START_PULSING 16'h0019
`define CMD_WRITE_PINS    16'h0014
`define CMD_WRITE_GROUP_B 16'h001C
`define CMD_POLL_CONV     16'h0714
`define CMD_CLEAR_PINS    16'h0018
`define CMD_MUTE          16'h0028
`define CMD_RESUME        16'h0029

// Check code generator polynomial and seed.
`define CHECK_POLY 16'h4599
`define CHECK_SEED 16'h0010

// Data words that follow each write command.
`define WORDS_GROUP_A 2'h3
`define WORDS_GROUP_B 2'h1

// Nibble codes: 1 to 7 pulses, steady high; everything else drives low.
`define NIB_PULSE_MAX 4'h7
`define NIB_HIGH      4'h8

// Pulse timing in nanoseconds, and the clock period.
`define CLK_PERIOD_NS  5
`define PULSE_PERIOD_NS 155000
`define PULSE_WIDTH_NS  77600

`endif

// *** logic/balance_pin_pulse_sequencer_pkg.sv ***
// Types of the balancing pin pulse sequencer.
// Assumes nothing of its surroundings.
`default_nettype none
package balance_pin_pulse_sequencer_pkg;

  // Framing state of the serial command decoder.
  typedef enum logic [2:0] {
    st_cmd,
    st_chk,
    st_data,
    st_dchk,
    st_poll,
    st_skip
  } frame_state_t;

endpackage
`default_nettype wire

// *** sim/balance_pin_pulse_sequencer_monitor.sv ***
// Checker of the pulse sequencer's top-level ports.
// Assumes it is bound into every instance of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module balance_pin_pulse_sequencer_monitor #(
  parameter int unsigned PINS       = 15,
  parameter int unsigned PERIOD_CYC = 31000,
  parameter int unsigned WIDTH_CYC  = 15520
) (
  // System side.
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            ce,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic            pready,
  input wire logic [31:0]     prdata,
  input wire logic            pslverr,
  // Serial port and pins.
  input wire logic            sck,
  input wire logic            csb_n,
  input wire logic            sdi,
  input wire logic            sdo_out,
  input wire logic            sdo_oe,
  input wire logic            port_a_mode_select_pin,
  input wire logic [PINS-1:0] balance_pin
);
  int unsigned since_rise;
  int unsigned high_run;
  logic        dis0;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles since pin 0 last rose; saturates, so a first rise always passes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      since_rise <= PERIOD_CYC;
    else if ($rose(balance_pin[0]))
      since_rise <= 1;
    else if (since_rise < PERIOD_CYC)
      since_rise <= since_rise + 1;
  end

  // Length of the current high run on pin 0.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      high_run <= 0;
    else
      high_run <= balance_pin[0] ? high_run + 1 : 0;
  end

  // Discharge bit 0 as last written over the bus.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      dis0 <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      dis0 <= pwdata[0];
  end

  a_pulse_spacing: assert property (
    $rose(balance_pin[0]) |-> since_rise >= PERIOD_CYC)
    else $error("pulse repeated before a full period");
  a_pulse_width: assert property (
    high_run <= WIDTH_CYC)
    else $error("pulse longer than its width");
  a_discharge_low: assert property (
    dis0 && $past(dis0, 3) |-> !balance_pin[0])
    else $error("discharge bit did not force pin low");
  a_sdo_only_low: assert property (
    sdo_oe |-> !sdo_out && !csb_n)
    else $error("data output driven high");
  a_pins_reset_low: assert property (
    $fell(rst) |-> balance_pin == '0)
    else $error("pins not low after reset");
  a_error_unmapped: assert property (
    psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("no error on unmapped access");
  a_error_access_only: assert property (
    pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_ready_tracks_ce: assert property (
    pready == ce)
    else $error("ready differs from enable");
endmodule // balance_pin_pulse_sequencer_monitor

bind balance_pin_pulse_sequencer balance_pin_pulse_sequencer_monitor #(
  .PINS(PINS), .PERIOD_CYC(PERIOD_CYC), .WIDTH_CYC(WIDTH_CYC)
) mon (
  .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .sck(sck), .csb_n(csb_n),
  .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
  .port_a_mode_select_pin(port_a_mode_select_pin),
  .balance_pin(balance_pin)
);
`default_nettype wire

// *** sim/balance_pin_pulse_sequencer_tb_top.sv ***
// Self-checking bench of the pulse sequencer.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "balance_pin_pulse_sequencer_defs.svh"
module balance_pin_pulse_sequencer_tb_top;
  localparam int unsigned PER = 200;
  localparam int unsigned WID = 100;
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr;
  logic        sck, csb_n, sdi, sdo_out, sdo_oe, mode_pin, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] balance_pin;
  int          num_errors, n_compared, rises0, rises1, lows;

  balance_pin_pulse_sequencer #(
    .PINS(15), .PERIOD_CYC(PER), .WIDTH_CYC(WID)
  ) uut (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sck(sck), .csb_n(csb_n),
    .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .port_a_mode_select_pin(mode_pin), .balance_pin(balance_pin));
  serial_host_model host (.sck(sck), .csb_n(csb_n), .sdi(sdi),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe));

  // System clock and pulse counters.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge balance_pin[0]) rises0++;
  always @(posedge balance_pin[1]) rises1++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors %0d, compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One bus transfer; a stall past the bound ends the run.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      num_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic cmd(input logic [15:0] c, input logic [47:0] d,
                     input int n, input logic bad);
    host.frame(c, d, n, bad, 0, lows);
  endtask

  task automatic pin_is(input int i, input logic v);
    for (int n = 0; n < 400 && balance_pin[i] !== v; n++)
      @(posedge clk);
    chk(balance_pin[i], v);
    if (balance_pin[i] !== v)
      close_out();
  endtask

  // Reset values, read-only status, unmapped place, ready low while ce is low.
  task automatic t_regs;
    rdc(`REG_DISCHARGE_OFS, 32'h0000_0000);
    rdc(`REG_STATUS_OFS, 32'h0000_0004);
    rdc(8'h40, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, `REG_DISCHARGE_OFS, 32'hFFFF_FFFF);
    rdc(`REG_DISCHARGE_OFS, 32'h0000_7FFF);
    apb(1'b1, `REG_DISCHARGE_OFS, 32'h0000_0000);
    apb(1'b1, `REG_STATUS_OFS, 32'hFFFF_FFFF);
    rdc(`REG_STATUS_OFS, 32'h0000_0004);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pready, 1'b0);
    ce <= 1'b1;
  endtask

  // Bad start check, then three and one pulses polled to the end.
  task automatic t_pulses;
    cmd(`CMD_WRITE_PINS, 48'h0000_0000_0013, 3, 1'b0);
    rdc(`REG_NIBBLE_LO_OFS, 32'h0000_0013);
    cmd(`CMD_START_PULSING, 48'h0000_0000_0000, 0, 1'b1);
    repeat (4 * PER) @(posedge clk);
    chk(rises0, 0);
    host.frame(`CMD_START_PULSING, 48'h0000_0000_0000, 0, 1'b0, 2000, lows);
    chk(lows > PER - 8 && lows < PER + 8, 1'b1);
    chk(rises0, 3);
    chk(rises1, 1);
  endtask

  // A write arriving mid-train, a poll to the end, a corrupted data check.
  task automatic t_busy_bad;
    int n;
    cmd(`CMD_START_PULSING, 48'h0000_0000_0000, 0, 1'b0);
    cmd(`CMD_WRITE_PINS, 48'h0000_0000_0077, 3, 1'b0);
    host.frame(`CMD_POLL_CONV, 48'h0000_0000_0000, 0, 1'b0, 2000, lows);
    chk(lows > 0, 1'b1);
    n = 0;
    do begin
      apb(1'b0, `REG_STATUS_OFS, 32'h0000_0000);
      n++;
    end while (rd[`STAT_BUSY_BIT] !== 1'b0 && n < 1000);
    if (n >= 1000) begin
      num_errors++;
      close_out();
    end
    chk(rd[`STAT_BUSY_BIT], 1'b0);
    rdc(`REG_NIBBLE_LO_OFS, 32'h0000_0013);
    cmd(`CMD_WRITE_PINS, 48'h0000_0000_0055, 3, 1'b1);
    rdc(`REG_NIBBLE_LO_OFS, 32'h0000_0000);
    rdc(`REG_STATUS_OFS, 32'h0000_000C);
  endtask

  // Clear in mid-train stops the pulses at once.
  task automatic t_clear;
    int r;
    cmd(`CMD_WRITE_PINS, 48'h0000_0000_0007, 3, 1'b0);
    cmd(`CMD_START_PULSING, 48'h0000_0000_0000, 0, 1'b0);
    pin_is(0, 1'b1);
    cmd(`CMD_CLEAR_PINS, 48'h0000_0000_0000, 0, 1'b0);
    r = rises0;
    repeat (3 * PER) @(posedge clk);
    chk(rises0, r);
    rdc(`REG_NIBBLE_LO_OFS, 32'h0000_0000);
    rdc(`REG_STATUS_OFS, 32'h0000_0004);
  endtask

  // Steady high on pin 14 through mute, resume and discharge.
  task automatic t_mute;
    cmd(`CMD_WRITE_GROUP_B, 48'h0800_0000_0000, 1, 1'b0);
    cmd(`CMD_START_PULSING, 48'h0000_0000_0000, 0, 1'b0);
    pin_is(14, 1'b1);
    cmd(`CMD_MUTE, 48'h0000_0000_0000, 0, 1'b0);
    pin_is(14, 1'b0);
    apb(1'b1, `REG_STATUS_OFS, 32'h0000_0000);
    rdc(`REG_STATUS_OFS, 32'h0000_0006);
    rdc(`REG_NIBBLE_HI_OFS, 32'h0800_0000);
    cmd(`CMD_RESUME, 48'h0000_0000_0000, 0, 1'b0);
    pin_is(14, 1'b1);
    apb(1'b1, `REG_DISCHARGE_OFS, 32'h0000_4000);
    pin_is(14, 1'b0);
    apb(1'b1, `REG_DISCHARGE_OFS, 32'h0000_0000);
    pin_is(14, 1'b1);
  endtask

  // With the mode pin high the port ignores a mute.
  task automatic t_mode;
    mode_pin <= 1'b1;
    cmd(`CMD_MUTE, 48'h0000_0000_0000, 0, 1'b0);
    repeat (20) @(posedge clk);
    chk(balance_pin[14], 1'b1);
    rdc(`REG_STATUS_OFS, 32'h0000_0000);
    mode_pin <= 1'b0;
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mode_pin = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_regs();
    t_pulses();
    t_busy_bad();
    t_clear();
    t_mute();
    t_mode();
    close_out();
  end
endmodule // balance_pin_pulse_sequencer_tb_top
`default_nettype wire

// *** sim/serial_host_model.sv ***
// Host controller on the four-wire command port.
// Assumes an open-drain data line with a pull-up resistor.
`timescale 1ns/1ps
`default_nettype none
`include "balance_pin_pulse_sequencer_defs.svh"
module serial_host_model (
  // Lines toward the device.
  output var logic sck,
  output var logic csb_n,
  output var logic sdi,
  // Open-drain data from the device.
  input wire logic sdo_out,
  input wire logic sdo_oe
);
  logic      [15:0] crc;
  wire logic        sdo_line;

  // The pull-up wins unless the device pulls low.
  assign sdo_line = sdo_oe ? sdo_out : 1'b1;

  // Idle with the clock high, as polarity 1 requires.
  initial begin
    sck = 1'b1;
    csb_n = 1'b1;
    sdi = 1'b1;
  end

  // One bit: data changes on the falling edge, stable at the rising one.
  task automatic shift(input logic b, output logic s);
    sck = 1'b0;
    sdi = b;
    #7.5; // Half period of the 15 ns sck period.
    sck = 1'b1;
    s = sdo_line;
    crc = {crc[14:0], 1'b0} ^ ((b ^ crc[15]) ? `CHECK_POLY : 16'h0000);
    #7.5;
  endtask

  task automatic word(input logic [15:0] w);
    logic s;
    for (int i = 15; i >= 0; i--)
      shift(w[i], s);
  endtask

  // Whole frame; bad corrupts the last check word, np adds poll clocks.
  task automatic frame(input logic [15:0] c, input logic [47:0] d,
                       input int n, input logic bad, input int np,
                       output int lows);
    logic s;
    lows = 0;
    s = 1'b0;
    csb_n = 1'b0;
    #10.3;
    crc = `CHECK_SEED;
    word(c);
    word(crc ^ {15'h0000, bad && n == 0});
    crc = `CHECK_SEED;
    for (int k = 0; k < n; k++)
      word(d[47-16*k -: 16]);
    if (n > 0)
      word(crc ^ {15'h0000, bad});
    // The first clocks may still read high while the start crosses over.
    for (int i = 0; i < np && (i < 8 || s !== 1'b1); i++) begin
      shift(1'b1, s);
      lows += (s === 1'b0);
    end
    #10;
    csb_n = 1'b1;
    #30;
  endtask
endmodule // serial_host_model
`default_nettype wire
